//--- hdl/pps_top.sv
// Pushbutton power on/off sequencer with an AXI4-Lite control and status port.
`timescale 1ns/1ps
`include "pps_map.svh"

module pps_top #(
    parameter bit ENABLE_ACTIVE_LOW = 1'b0,
    parameter int TICK_CYCLES = `PPS_TICK_US * `PPS_CLK_MHZ
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic BUTTON_N_I,
    input wire logic MONITOR_I,
    input wire logic RELEASE_N_I,
    input wire logic MODE_SEL_I,
    input wire logic FORCED_OFF_TIMER_PIN_I,
    output logic SYS_ENABLE_O,
    output logic POWER_DOWN_INT_N_O,
    output logic POWER_DOWN_INT_N_OE_O,
    output logic MONITOR_LEVEL_STATUS_O,
    input wire logic [`PPS_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [`PPS_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    import pps_pkg::*;

    // Sync bit positions within the synchroniser vectors.
    localparam int SB = 0;
    localparam int SM = 1;
    localparam int SR = 2;
    localparam int SS = 3;
    localparam int ST = 4;

    logic [1:0] rst_sy;
    logic rst_n;
    pps_core_s s_r;
    pps_core_s s_nxt;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_sy <= 2'b00;
        end else begin
            rst_sy <= {rst_sy[0], 1'b1};
        end
    end
    assign rst_n = rst_sy[1];

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a[7:2] == off[7:2]);
    endfunction

    // ----------------------------------------------------------------
    // Sequencer and register file
    // ----------------------------------------------------------------
    always_comb begin
        logic btn;
        logic mon;
        logic rel_n;
        logic sel;
        logic tick_wrap;
        logic restart;
        logic [9:0] target;
        logic done;
        logic btn_fall;
        logic mon_rise;
        logic mon_fall;
        logic tmr_rise;
        logic go_off;
        btn = s_r.sy2[SB];
        mon = s_r.sy2[SM];
        rel_n = s_r.sy2[SR];
        sel = s_r.sy2[SS];
        s_nxt = s_r;
        restart = 1'b0;
        go_off = 1'b0;
        s_nxt.sy1 = {FORCED_OFF_TIMER_PIN_I, MODE_SEL_I, RELEASE_N_I, MONITOR_I, BUTTON_N_I};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.btn_d = btn;
        s_nxt.mon_d = mon;
        s_nxt.tmr_d = s_r.sy2[ST];
        btn_fall = s_r.btn_d && !btn;
        mon_rise = !s_r.mon_d && mon;
        mon_fall = s_r.mon_d && !mon;
        tmr_rise = !s_r.tmr_d && s_r.sy2[ST];

        // Every window counts whole ticks from a restart, so none can end early.
        // shared tick base
        tick_wrap = (s_r.tick == 17'(TICK_CYCLES - 1));
        s_nxt.tick = tick_wrap ? 17'h00000 : s_r.tick + 17'h00001;
        if (tick_wrap) begin
            s_nxt.ms = s_r.ms + 10'h001;
        end
        case (s_r.st)
            PPS_ON_DEB, PPS_OFF_DEB: target = `PPS_DEB_MS;
            PPS_INT_MIN: target = `PPS_INT_MIN_MS;
            PPS_ON_BLANK: target = `PPS_BLANK_MS;
            default: target = `PPS_LOCK_MS;
        endcase
        done = tick_wrap && (s_r.ms == target - 10'h001);

        case (s_r.st)
            PPS_OFF: begin
                if (btn_fall) begin
                    s_nxt.st = PPS_ON_DEB;
                    s_nxt.mon_src = 1'b0;
                    restart = 1'b1;
                end else if (mon_rise || (s_r.first && mon)) begin
                    s_nxt.st = PPS_ON_DEB;
                    s_nxt.mon_src = 1'b1;
                    restart = 1'b1;
                end
                s_nxt.first = 1'b0;
            end
            PPS_ON_DEB: begin
                if (!s_r.mon_src && btn) begin
                    s_nxt.st = mon ? PPS_ON_DEB : PPS_OFF;
                    s_nxt.mon_src = mon;
                    restart = 1'b1;
                end else if (s_r.mon_src && !mon) begin
                    s_nxt.st = PPS_OFF;
                end else if (done) begin
                    s_nxt.st = PPS_ON_BLANK;
                    restart = 1'b1;
                end
            end
            PPS_ON_BLANK: begin
                if (done) begin
                    if (!rel_n) begin
                        go_off = 1'b1;
                    end else begin
                        s_nxt.st = PPS_ON_RUN;
                        s_nxt.armed = btn;
                    end
                end
            end
            PPS_ON_RUN: begin
                if (btn) begin
                    s_nxt.armed = 1'b1;
                end
                if (!rel_n) begin
                    go_off = 1'b1;
                end else if (s_r.armed && !btn) begin
                    s_nxt.st = PPS_OFF_DEB;
                    s_nxt.int_mon = 1'b0;
                    restart = 1'b1;
                end else if (mon_fall && s_r.mon_src && sel) begin
                    s_nxt.st = PPS_INT_MIN;
                    s_nxt.int_mon = 1'b1;
                    restart = 1'b1;
                end
            end
            PPS_OFF_DEB: begin
                if (!rel_n) begin
                    go_off = 1'b1;
                end else if (btn) begin
                    s_nxt.st = PPS_ON_RUN;
                end else if (done) begin
                    s_nxt.st = PPS_INT_MIN;
                    restart = 1'b1;
                end
            end
            PPS_INT_MIN: begin
                if (!rel_n) begin
                    go_off = 1'b1;
                end else if (done) begin
                    if (s_r.int_mon ? !mon : !btn) begin
                        s_nxt.st = PPS_TMR_CNT;
                        s_nxt.tmr_cnt = 5'h00;
                    end else begin
                        s_nxt.st = PPS_ON_RUN;
                    end
                end
            end
            PPS_TMR_CNT: begin
                if (tmr_rise && s_r.tmr_cnt != `PPS_TMR_PERIODS) begin
                    s_nxt.tmr_cnt = s_r.tmr_cnt + 5'h01;
                end
                if (!rel_n) begin
                    go_off = 1'b1;
                end else if (s_r.int_mon ? mon : btn) begin
                    s_nxt.st = PPS_ON_RUN;
                end else begin
                    case (s_r.tmr_mode)
                        PPS_TMR_OPEN: go_off = 1'b1;
                        PPS_TMR_GROUND: go_off = 1'b0;
                        default: go_off = (s_r.tmr_cnt == `PPS_TMR_PERIODS);
                    endcase
                end
            end
            PPS_WAIT_REL: begin
                if (btn) begin
                    s_nxt.st = PPS_LOCKOUT;
                    restart = 1'b1;
                end
            end
            PPS_LOCKOUT: begin
                if (done) begin
                    s_nxt.st = PPS_OFF;
                end
            end
            default: begin
                s_nxt.st = PPS_OFF;
            end
        endcase

        // Requested and forced turn-offs share one exit, so lockout entry is identical.
        if (go_off) begin
            s_nxt.st = btn ? PPS_LOCKOUT : PPS_WAIT_REL;
            restart = 1'b1;
        end
        if (restart) begin
            s_nxt.tick = 17'h00000;
            s_nxt.ms = 10'h000;
        end

        s_nxt.en = (s_nxt.st == PPS_ON_BLANK) || (s_nxt.st == PPS_ON_RUN)
            || (s_nxt.st == PPS_OFF_DEB) || (s_nxt.st == PPS_INT_MIN)
            || (s_nxt.st == PPS_TMR_CNT);
        s_nxt.int_low = (s_nxt.st == PPS_INT_MIN) || (s_nxt.st == PPS_TMR_CNT);

        // Write channel: address and data may arrive in either order.
        if (S_AXI_AWVALID_I && !s_r.axi.aw_ok && !s_r.axi.bvalid) begin
            s_nxt.axi.aw_ok = 1'b1;
            s_nxt.axi.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !s_r.axi.w_ok && !s_r.axi.bvalid) begin
            s_nxt.axi.w_ok = 1'b1;
            s_nxt.axi.wdata = S_AXI_WDATA_I;
            s_nxt.axi.wstrb = S_AXI_WSTRB_I;
        end
        if (s_r.axi.aw_ok && s_r.axi.w_ok) begin
            s_nxt.axi.aw_ok = 1'b0;
            s_nxt.axi.w_ok = 1'b0;
            s_nxt.axi.bvalid = 1'b1;
            s_nxt.axi.bresp = `PPS_RESP_OKAY;
            if (addr_hit(s_r.axi.awaddr, `PPS_CTRL_OFFSET)) begin
                if (s_r.axi.wstrb[0]) begin
                    s_nxt.tmr_mode = pps_tmr_e'(
                        s_r.axi.wdata[`PPS_TMR_MODE_LSB +: `PPS_TMR_MODE_W]);
                end
            end else if (!addr_hit(s_r.axi.awaddr, `PPS_STATUS_OFFSET)) begin
                s_nxt.axi.bresp = `PPS_RESP_SLVERR;
            end
        end
        if (s_r.axi.bvalid && S_AXI_BREADY_I) begin
            s_nxt.axi.bvalid = 1'b0;
        end
        if (s_r.axi.rvalid && S_AXI_RREADY_I) begin
            s_nxt.axi.rvalid = 1'b0;
        end
        // Reads have no side effects, so a repeated read is harmless.
        if (S_AXI_ARVALID_I && !s_r.axi.rvalid) begin
            s_nxt.axi.rvalid = 1'b1;
            s_nxt.axi.rresp = `PPS_RESP_OKAY;
            s_nxt.axi.rdata = 32'h00000000;
            if (addr_hit(S_AXI_ARADDR_I, `PPS_CTRL_OFFSET)) begin
                s_nxt.axi.rdata[`PPS_TMR_MODE_LSB +: `PPS_TMR_MODE_W] = s_r.tmr_mode;
            end else if (addr_hit(S_AXI_ARADDR_I, `PPS_STATUS_OFFSET)) begin
                s_nxt.axi.rdata[`PPS_ST_ENABLE_BIT] = s_r.en;
                s_nxt.axi.rdata[`PPS_ST_INT_BIT] = s_r.int_low;
                s_nxt.axi.rdata[`PPS_ST_MON_SRC_BIT] = s_r.mon_src;
                s_nxt.axi.rdata[`PPS_ST_MON_LVL_BIT] = mon;
                s_nxt.axi.rdata[`PPS_ST_ARMED_BIT] = s_r.armed;
                s_nxt.axi.rdata[`PPS_ST_OFF_BIT] = (s_r.st == PPS_OFF);
            end else begin
                s_nxt.axi.rresp = `PPS_RESP_SLVERR;
            end
        end
    end

    // Power-up behaves as a lockout so a monitor already high turns on afterwards.
    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= PPS_LOCKOUT;
            s_r.sy1 <= 5'h01;
            s_r.sy2 <= 5'h01;
            s_r.btn_d <= 1'b1;
            s_r.first <= 1'b1;
            s_r.tmr_mode <= PPS_TMR_OPEN;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // build-time enable polarity
    assign SYS_ENABLE_O = s_r.en ^ ENABLE_ACTIVE_LOW;
    // Open drain: the pin is only ever pulled low, the board pulls it high.
    assign POWER_DOWN_INT_N_O = 1'b0;
    assign POWER_DOWN_INT_N_OE_O = s_r.int_low;
    assign MONITOR_LEVEL_STATUS_O = s_r.sy2[SM];

    assign S_AXI_AWREADY_O = !s_r.axi.aw_ok && !s_r.axi.bvalid;
    assign S_AXI_WREADY_O = !s_r.axi.w_ok && !s_r.axi.bvalid;
    assign S_AXI_BVALID_O = s_r.axi.bvalid;
    assign S_AXI_BRESP_O = s_r.axi.bresp;
    assign S_AXI_ARREADY_O = !s_r.axi.rvalid;
    assign S_AXI_RVALID_O = s_r.axi.rvalid;
    assign S_AXI_RDATA_O = s_r.axi.rdata;
    assign S_AXI_RRESP_O = s_r.axi.rresp;

endmodule

//--- pkg/pps_map.svh
// Register offsets, field positions, response codes and timing counts of the power sequencer.
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PPS_ADDR_W 8
`define PPS_CTRL_OFFSET 8'h00
`define PPS_STATUS_OFFSET 8'h04
`define PPS_TMR_MODE_LSB 0
`define PPS_TMR_MODE_W 2
`define PPS_ST_ENABLE_BIT 0
`define PPS_ST_INT_BIT 1
`define PPS_ST_MON_SRC_BIT 2
`define PPS_ST_MON_LVL_BIT 3
`define PPS_ST_ARMED_BIT 4
`define PPS_ST_OFF_BIT 5
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPS_CLK_MHZ 125
`define PPS_TICK_US 1000
`define PPS_DEB_MS 10'd32
`define PPS_INT_MIN_MS 10'd32
`define PPS_BLANK_MS 10'd512
`define PPS_LOCK_MS 10'd1000
`define PPS_TMR_PERIODS 5'd16

`endif

//--- pkg/pps_pkg.sv
// Types shared by the pushbutton power sequencer.
package pps_pkg;

    typedef enum logic [3:0] {
        PPS_OFF, PPS_ON_DEB, PPS_ON_BLANK, PPS_ON_RUN, PPS_OFF_DEB,
        PPS_INT_MIN, PPS_TMR_CNT, PPS_WAIT_REL, PPS_LOCKOUT
    } pps_state_e;

    typedef enum logic [1:0] {
        PPS_TMR_OPEN, PPS_TMR_GROUND, PPS_TMR_EXT
    } pps_tmr_e;

    typedef struct packed {
        logic [7:0] awaddr;
        logic aw_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_ok;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pps_axi_s;

    typedef struct packed {
        pps_state_e st;
        logic [16:0] tick;
        logic [9:0] ms;
        logic [4:0] tmr_cnt;
        logic [4:0] sy1;
        logic [4:0] sy2;
        logic btn_d;
        logic mon_d;
        logic tmr_d;
        logic mon_src;
        logic int_mon;
        logic armed;
        logic first;
        pps_tmr_e tmr_mode;
        logic en;
        logic int_low;
        pps_axi_s axi;
    } pps_core_s;

endpackage

//--- verif/pps_top_sva.sv
// Assertion checker on the pins of the pushbutton power sequencer.
`timescale 1ns/1ps
module pps_top_sva #(
    parameter bit ENABLE_ACTIVE_LOW = 1'h0,
    parameter int TICK_CYCLES = 4
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic BUTTON_N_I,
    input wire logic MONITOR_I,
    input wire logic RELEASE_N_I,
    input wire logic SYS_ENABLE_O,
    input wire logic POWER_DOWN_INT_N_O,
    input wire logic POWER_DOWN_INT_N_OE_O,
    input wire logic MONITOR_LEVEL_STATUS_O
);
    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    localparam int DEB = 32 * TICK_CYCLES;
    localparam int BLANK = 512 * TICK_CYCLES;
    localparam int LOCK = 1000 * TICK_CYCLES;
    logic en;
    logic [15:0] btn_lo_r, mon_hi_r, on_r, off_r, oe_r;
    logic rel_seen_r;
    logic [2:0] up_r;
    assign en = SYS_ENABLE_O ^ ENABLE_ACTIVE_LOW;
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (&v) ? v : v + 16'h1;
    endfunction
    // Counters saturate so that long idle spells never wrap into a false short count.
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            {btn_lo_r, mon_hi_r, on_r, off_r, oe_r, rel_seen_r, up_r} <= '0;
        end else begin
            btn_lo_r <= BUTTON_N_I ? 16'h0 : inc(btn_lo_r);
            mon_hi_r <= MONITOR_I ? inc(mon_hi_r) : 16'h0;
            on_r <= en ? inc(on_r) : 16'h0;
            off_r <= en ? 16'h0 : inc(off_r);
            oe_r <= POWER_DOWN_INT_N_OE_O ? inc(oe_r) : 16'h0;
            rel_seen_r <= POWER_DOWN_INT_N_OE_O & (rel_seen_r | ~RELEASE_N_I);
            up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RSTN_I);
    sequence s_mon_steady;
        $stable(MONITOR_I) [*3];
    endsequence
    sequence s_kill_seen;
        en && on_r > BLANK + 16 && !RELEASE_N_I;
    endsequence
    property p_on_deb;
        $rose(en) |-> btn_lo_r >= DEB - 2 || mon_hi_r >= DEB - 2;
    endproperty
    a_on_deb: assert property (p_on_deb) else $error("enable before debounce");
    property p_blank_hold;
        $fell(en) |-> on_r >= BLANK - 2;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("enable dropped in blanking");
    property p_kill;
        s_kill_seen |-> ##[1:6] (!en && !POWER_DOWN_INT_N_OE_O);
    endproperty
    a_kill: assert property (p_kill) else $error("kill not obeyed");
    property p_int_deb;
        $rose(POWER_DOWN_INT_N_OE_O) |-> btn_lo_r >= DEB - 2 || !MONITOR_I;
    endproperty
    a_int_deb: assert property (p_int_deb) else $error("interrupt before debounce");
    property p_int_width;
        $fell(POWER_DOWN_INT_N_OE_O) |-> oe_r >= DEB - 2 || rel_seen_r;
    endproperty
    a_int_width: assert property (p_int_width) else $error("interrupt too short");
    property p_int_on;
        POWER_DOWN_INT_N_OE_O |-> POWER_DOWN_INT_N_O == 1'h0 && (en || $past(en));
    endproperty
    a_int_on: assert property (p_int_on) else $error("interrupt while off");
    property p_lockout;
        $rose(en) |-> off_r >= LOCK - 2;
    endproperty
    a_lockout: assert property (p_lockout) else $error("turn-on inside lockout");
    property p_status;
        (up_r == 3'h7) ##0 s_mon_steady |-> MONITOR_LEVEL_STATUS_O == MONITOR_I;
    endproperty
    a_status: assert property (p_status) else $error("status not following");
endmodule

bind pps_top pps_top_sva #(.ENABLE_ACTIVE_LOW(ENABLE_ACTIVE_LOW), .TICK_CYCLES(TICK_CYCLES)) i_sva (
    .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .BUTTON_N_I(BUTTON_N_I), .MONITOR_I(MONITOR_I),
    .RELEASE_N_I(RELEASE_N_I), .SYS_ENABLE_O(SYS_ENABLE_O), .POWER_DOWN_INT_N_O(POWER_DOWN_INT_N_O),
    .POWER_DOWN_INT_N_OE_O(POWER_DOWN_INT_N_OE_O), .MONITOR_LEVEL_STATUS_O(MONITOR_LEVEL_STATUS_O)
);

//--- verif/pps_far_end.sv
// Behavioural processor and timer capacitor around the power sequencer.
`timescale 1ns/1ps
module pps_far_end #(
    parameter int BOOT_CYC = 100,
    parameter int ACK_CYC = 40,
    parameter int TMR_HALF = 8
) (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic int_i,
    input wire logic boot_ok_i,
    input wire logic ack_i,
    output logic release_n_o,
    output logic timer_o
);
    int boot_r = 0;
    int ack_r = 0;
    int tmr_r = 0;
    initial begin
        release_n_o = 1'h0;
        timer_o = 1'h0;
    end
    always @(posedge clk_i) begin
        boot_r <= en_i ? boot_r + 1 : 0;
        ack_r <= int_i ? ack_r + 1 : 0;
        tmr_r <= (int_i && tmr_r < TMR_HALF - 1) ? tmr_r + 1 : 0;
        // The oscillator stands still unless the interrupt is asserted.
        timer_o <= int_i && ((tmr_r == TMR_HALF - 1) ? !timer_o : timer_o);
        if (!en_i) begin
            // An unpowered processor cannot hold the kill line high.
            release_n_o <= 1'h0;
        end else if (boot_ok_i && boot_r == BOOT_CYC) begin
            release_n_o <= 1'h1;
        end else if (ack_i && ack_r >= ACK_CYC) begin
            release_n_o <= 1'h0;
        end
    end
endmodule

//--- verif/pushbutton_power_sequencer_tb.sv
// Self-checking testbench of the pushbutton power sequencer.
`timescale 1ns/1ps
`include "pps_map.svh"
module pushbutton_power_sequencer_tb;
    localparam int T = 4;
    logic mclk = 1'h0, rst_n = 1'h0, btn_n = 1'h1, mon = 1'h0, sel = 1'h1, boot_ok = 1'h1;
    logic ack = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic rel_n, tmr_pin, en, int_n, int_oe, mon_st, awready, wready, bvalid, arready, rvalid;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    always #4 mclk = ~mclk;
    pps_top #(.ENABLE_ACTIVE_LOW(1'h0), .TICK_CYCLES(T)) i_dut (
        .MCLK_I(mclk), .RSTN_I(rst_n), .BUTTON_N_I(btn_n), .MONITOR_I(mon),
        .RELEASE_N_I(rel_n), .MODE_SEL_I(sel), .FORCED_OFF_TIMER_PIN_I(tmr_pin),
        .SYS_ENABLE_O(en), .POWER_DOWN_INT_N_O(int_n), .POWER_DOWN_INT_N_OE_O(int_oe),
        .MONITOR_LEVEL_STATUS_O(mon_st), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
    pps_far_end i_far (.clk_i(mclk), .en_i(en), .int_i(int_oe), .boot_ok_i(boot_ok),
        .ack_i(ack), .release_n_o(rel_n), .timer_o(tmr_pin));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic fail_out();
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        end_sim();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k * T) @(posedge mclk);
    endtask
    // Samples on the falling edge so that the design's updates have landed.
    task automatic wt(input bit oe_sel, input logic v, input int lim, output int cnt);
        logic s;
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
            s = oe_sel ? int_oe : en;
        end while (s !== v && cnt < lim);
        if (s !== v) fail_out();
        else @(posedge mclk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic at, wtk, bt;
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        bt = 1'h0;
        for (i = 0; i < 50 && bt !== 1'h1; i++) begin
            @(negedge mclk);
            at = awvalid & awready;
            wtk = wvalid & wready;
            bt = bvalid;
            rs = bresp;
            @(posedge mclk);
            if (at) awvalid <= 1'h0;
            if (wtk) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        @(posedge mclk);
        if (bt !== 1'h1) fail_out();
        else chk(rs, exp);
    endtask
    task automatic axr(input logic [7:0] a);
        logic at, rt;
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        rt = 1'h0;
        for (i = 0; i < 50 && rt !== 1'h1; i++) begin
            @(negedge mclk);
            at = arvalid & arready;
            rt = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge mclk);
            if (at) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        @(posedge mclk);
        if (rt !== 1'h1) fail_out();
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'h1;
        ticks(4);
        axr(`PPS_CTRL_OFFSET);
        chk(rd, 32'h0);
        axr(8'h08);
        chk(rs, `PPS_RESP_SLVERR);
        axw(8'h0c, 32'h1, `PPS_RESP_SLVERR);
        axw(`PPS_STATUS_OFFSET, 32'hff, `PPS_RESP_OKAY);
        ticks(1010);
        btn_n <= 1'h0;
        ticks(20);
        btn_n <= 1'h1;
        ticks(40);
        chk(en, 1'h0);
        btn_n <= 1'h0;
        wt(0, 1'h1, 45 * T, n);
        chk(n >= 31 * T && n <= 35 * T, 1'h1);
        ticks(540);
        chk(en, 1'h1);
        chk(int_oe, 1'h0);
        btn_n <= 1'h1;
        ticks(4);
        btn_n <= 1'h0;
        wt(1, 1'h1, 45 * T, n);
        chk(n >= 31 * T && n <= 35 * T, 1'h1);
        btn_n <= 1'h1;
        ticks(28);
        chk(int_oe, 1'h1);
        wt(1, 1'h0, 8 * T, n);
        chk(en, 1'h1);
        btn_n <= 1'h0;
        wt(0, 1'h0, 80 * T, n);
        chk(n >= 63 * T && n <= 68 * T, 1'h1);
        chk(int_oe, 1'h0);
        ticks(950);
        btn_n <= 1'h1;
        ticks(100);
        btn_n <= 1'h0;
        ticks(40);
        chk(en, 1'h0);
        btn_n <= 1'h1;
        ticks(900);
        btn_n <= 1'h0;
        wt(0, 1'h1, 45 * T, n);
        chk(n >= 31 * T && n <= 35 * T, 1'h1);
        btn_n <= 1'h1;
        ticks(520);
        mon <= 1'h1;
        ticks(10);
        mon <= 1'h0;
        ticks(10);
        chk(int_oe, 1'h0);
        axw(`PPS_CTRL_OFFSET, 32'h1, `PPS_RESP_OKAY);
        btn_n <= 1'h0;
        ticks(150);
        chk({en, int_oe}, 2'h3);
        ack <= 1'h1;
        wt(0, 1'h0, 20 * T, n);
        ticks(1);
        chk(int_oe, 1'h0);
        ack <= 1'h0;
        btn_n <= 1'h1;
        ticks(1010);
        axw(`PPS_CTRL_OFFSET, 32'h2, `PPS_RESP_OKAY);
        mon <= 1'h1;
        wt(0, 1'h1, 45 * T, n);
        chk(n >= 31 * T && n <= 35 * T, 1'h1);
        chk(mon_st, 1'h1);
        axr(`PPS_STATUS_OFFSET);
        chk(rd[`PPS_ST_MON_SRC_BIT], 1'h1);
        ticks(520);
        btn_n <= 1'h0;
        wt(1, 1'h1, 45 * T, n);
        ticks(40);
        btn_n <= 1'h1;
        wt(1, 1'h0, 4 * T, n);
        chk(n <= 5 && en === 1'h1, 1'h1);
        mon <= 1'h0;
        wt(1, 1'h1, 2 * T, n);
        chk(n <= 6, 1'h1);
        ack <= 1'h1;
        wt(0, 1'h0, 20 * T, n);
        ack <= 1'h0;
        ticks(1010);
        sel <= 1'h0;
        mon <= 1'h1;
        wt(0, 1'h1, 45 * T, n);
        ticks(520);
        mon <= 1'h0;
        ticks(20);
        chk(int_oe, 1'h0);
        btn_n <= 1'h0;
        wt(0, 1'h0, 140 * T, n);
        chk(n >= 124 * T && n <= 131 * T, 1'h1);
        btn_n <= 1'h1;
        ticks(1010);
        boot_ok <= 1'h0;
        btn_n <= 1'h0;
        wt(0, 1'h1, 45 * T, n);
        btn_n <= 1'h1;
        wt(0, 1'h0, 530 * T, n);
        chk(n >= 510 * T && n <= 516 * T, 1'h1);
        end_sim();
    end
endmodule
